// ==== logic/psc_divider.sv ====
// Divides the prescaler clock enable by two to the selected power
`timescale 1ns/10ps
module psc_divider
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Prescaler enable in
   input wire logic prescaler_clock,
   // Tick out
   tick_if.div tk
);
   logic [7:0] div_cnt;
   logic [7:0] next_div_cnt;
   logic div_hit;

   // Low bits below the selected power must all be one before the tick passes
   assign div_hit = ((div_cnt | ~((8'h01 << tk.sel) - 8'h01)) == 8'hff);
   assign next_div_cnt = div_hit ? tmr_pkg::DIV_RESET : div_cnt + 8'h01;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         div_cnt <= tmr_pkg::DIV_RESET;
         tk.tick <= 1'b0;
      end
      else
      begin
         tk.tick <= prescaler_clock && div_hit;
         if (prescaler_clock)
         begin
            div_cnt <= next_div_cnt;
         end
      end
   end
endmodule

// ==== logic/tick_if.sv ====
// Count-clock tick bundle between the divider and the counter core
`timescale 1ns/10ps
interface tick_if;
   logic [2:0] sel;
   logic tick;
   modport div (input sel, output tick);
   modport core (output sel, input tick);
endinterface

// ==== logic/timer_event_pulse_counter.sv ====
// 16-bit timer, event counter and pulse-width counter with byte-wide access
`timescale 1ns/10ps
module timer_event_pulse_counter
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Time base and pin
   input wire logic prescaler_clock,
   input wire logic counter_input_pin,
   // Power state from the core
   input wire logic device_idle,
   // Events out
   output logic irq_req,
   output logic wake_up
);
   tick_if tk ();

   logic [7:0] counter_control_reg;
   logic [15:0] count;
   logic [15:0] preload;
   logic [7:0] low_wbuf;
   logic [7:0] low_rbuf;
   logic irq_flag;
   logic irq_en;
   logic pin_prev;
   tmr_pkg::pw_state_t pw_state;

   logic [1:0] mode_bits;
   tmr_pkg::mode_t op_mode;
   logic op_mode_sel_hi;
   logic op_mode_sel_lo;
   logic run_enable;
   logic edge_select;
   logic [2:0] clock_divide_sel;
   logic wr_ctrl;
   logic wr_lo;
   logic wr_hi;
   logic wr_irq;
   logic rd_lo;
   logic rd_hi;
   logic rd_irq;
   logic rd_ctrl;
   logic inhibit;
   logic pin_rise;
   logic pin_fall;
   logic start_edge;
   logic stop_edge;
   logic evt_edge;
   logic count_en;
   logic overflow;
   logic pw_stop;
   logic [15:0] next_count;
   logic [7:0] next_rdata;
   logic [7:0] ctrl_view;
   logic [7:0] irq_view;

   psc_divider u_div
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .prescaler_clock(prescaler_clock),
      .tk(tk.div)
   );

   // Control fields
   assign op_mode_sel_hi = counter_control_reg[tmr_pkg::MODE_HI_BIT];
   assign op_mode_sel_lo = counter_control_reg[tmr_pkg::MODE_LO_BIT];
   assign mode_bits = {op_mode_sel_hi, op_mode_sel_lo};
   assign op_mode = tmr_pkg::mode_t'(mode_bits);
   assign run_enable = counter_control_reg[tmr_pkg::RUN_BIT];
   assign edge_select = counter_control_reg[tmr_pkg::EDGE_BIT];
   assign clock_divide_sel = counter_control_reg[tmr_pkg::DIV_MSB:0];
   assign tk.sel = clock_divide_sel;

   // Address decode
   assign wr_ctrl = reg_write && (reg_addr == tmr_pkg::ADDR_CTRL);
   assign wr_lo = reg_write && (reg_addr == tmr_pkg::ADDR_CNT_LO);
   assign wr_hi = reg_write && (reg_addr == tmr_pkg::ADDR_CNT_HI);
   assign wr_irq = reg_write && (reg_addr == tmr_pkg::ADDR_IRQ);
   assign rd_ctrl = reg_read && (reg_addr == tmr_pkg::ADDR_CTRL);
   assign rd_lo = reg_read && (reg_addr == tmr_pkg::ADDR_CNT_LO);
   assign rd_hi = reg_read && (reg_addr == tmr_pkg::ADDR_CNT_HI);
   assign rd_irq = reg_read && (reg_addr == tmr_pkg::ADDR_IRQ);

   // Losing a tick here is accepted so that byte reads never tear
   assign inhibit = rd_lo || rd_hi || wr_hi;

   // The pin is only looked at on count ticks, which quantises edges
   assign pin_rise = tk.tick && counter_input_pin && !pin_prev;
   assign pin_fall = tk.tick && !counter_input_pin && pin_prev;
   assign evt_edge = edge_select ? pin_fall : pin_rise;
   assign start_edge = edge_select ? pin_rise : pin_fall;
   assign stop_edge = edge_select ? pin_fall : pin_rise;

   // Counting condition per mode
   always_comb
   begin
      count_en = 1'b0;
      unique case (op_mode)
         tmr_pkg::MODE_TIMER: count_en = tk.tick;
         tmr_pkg::MODE_EVENT: count_en = evt_edge;
         tmr_pkg::MODE_PULSE: count_en = tk.tick && (pw_state == tmr_pkg::PW_MEASURE)
            && !stop_edge;
         tmr_pkg::MODE_UNUSED: count_en = 1'b0;
      endcase
   end

   assign overflow = run_enable && count_en && !inhibit
      && (count == tmr_pkg::COUNT_FULL);
   assign pw_stop = run_enable && (op_mode == tmr_pkg::MODE_PULSE)
      && (pw_state == tmr_pkg::PW_MEASURE) && stop_edge;
   assign next_count = overflow ? preload : count + 16'h0001;

   // Read mux
   assign ctrl_view = {counter_control_reg[7:6], 1'b0, counter_control_reg[4:0]};
   assign irq_view = {5'h00, device_idle, irq_en, irq_flag};
   assign next_rdata = rd_ctrl ? ctrl_view :
                       rd_hi ? count[15:8] :
                       rd_lo ? low_rbuf :
                       rd_irq ? irq_view : 8'h00;

   // Register port
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         reg_rdata <= 8'h00;
         low_rbuf <= 8'h00;
         low_wbuf <= 8'h00;
         preload <= tmr_pkg::COUNT_RESET;
      end
      else
      begin
         reg_rdata <= next_rdata;
         if (rd_hi)
         begin
            low_rbuf <= count[7:0];
         end
         if (wr_lo)
         begin
            low_wbuf <= reg_wdata;
         end
         if (wr_hi)
         begin
            preload <= {reg_wdata, low_wbuf};
         end
      end
   end

   // Control register; the pulse stop clears run, software write clears it otherwise
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         counter_control_reg <= tmr_pkg::CTRL_RESET;
      end
      else if (wr_ctrl)
      begin
         counter_control_reg <= {reg_wdata[7:6], 1'b0, reg_wdata[4:0]};
      end
      else if (pw_stop)
      begin
         counter_control_reg[tmr_pkg::RUN_BIT] <= 1'b0;
      end
   end

   // Pulse-width sequencer, rearmed each time run is set
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pw_state <= tmr_pkg::PW_ARMED;
         pin_prev <= 1'b0;
      end
      else
      begin
         if (tk.tick || wr_ctrl)
         begin
            pin_prev <= counter_input_pin;
         end
         if (!run_enable || wr_ctrl)
         begin
            pw_state <= tmr_pkg::PW_ARMED;
         end
         else
         begin
            unique case (pw_state)
               tmr_pkg::PW_ARMED:
                  if (start_edge)
                  begin
                     pw_state <= tmr_pkg::PW_MEASURE;
                  end
               tmr_pkg::PW_MEASURE:
                  if (stop_edge)
                  begin
                     pw_state <= tmr_pkg::PW_ARMED;
                  end
            endcase
         end
      end
   end

   // Counter; the flag set wins over a clearing write
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         count <= tmr_pkg::COUNT_RESET;
         irq_flag <= 1'b0;
         irq_en <= 1'b0;
         irq_req <= 1'b0;
         wake_up <= 1'b0;
      end
      else
      begin
         if (wr_hi && !run_enable)
         begin
            count <= {reg_wdata, low_wbuf};
         end
         else if (run_enable && count_en && !inhibit)
         begin
            count <= next_count;
         end
         if (wr_irq)
         begin
            irq_en <= reg_wdata[tmr_pkg::IRQ_EN_BIT];
         end
         if (overflow)
         begin
            irq_flag <= 1'b1;
         end
         else if (wr_irq)
         begin
            irq_flag <= reg_wdata[tmr_pkg::IRQ_FLAG_BIT];
         end
         irq_req <= (overflow || irq_flag) && irq_en;
         wake_up <= overflow && device_idle;
      end
   end
endmodule

// ==== logic/tmr_pkg.sv ====
// Shared constants and types for the timer / event / pulse-width counter
package tmr_pkg;
   // Register indices on the plain register port
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_CNT_LO = 2'h1;
   localparam logic [1:0] ADDR_CNT_HI = 2'h2;
   localparam logic [1:0] ADDR_IRQ = 2'h3;
   // Control register fields
   localparam int MODE_HI_BIT = 7;
   localparam int MODE_LO_BIT = 6;
   localparam int RUN_BIT = 4;
   localparam int EDGE_BIT = 3;
   localparam int DIV_MSB = 2;
   // Interrupt register fields
   localparam int IRQ_FLAG_BIT = 0;
   localparam int IRQ_EN_BIT = 1;
   localparam int IDLE_BIT = 2;
   // Values after reset, and the full count at which the counter overflows
   localparam logic [7:0] CTRL_RESET = 8'h08;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_FULL = 16'hffff;
   localparam logic [7:0] DIV_RESET = 8'h00;
   typedef enum logic [1:0] {
      MODE_UNUSED = 2'h0,
      MODE_EVENT = 2'h1,
      MODE_TIMER = 2'h2,
      MODE_PULSE = 2'h3
   } mode_t;
   typedef enum {PW_ARMED, PW_MEASURE} pw_state_t;
endpackage

// ==== testbench/pin_source.sv ====
// Pulse source standing on the counter input pin
`timescale 1ns/10ps
module pin_source
(
   // Clock
   input wire logic clk_sys,
   // Command
   input wire logic start,
   input wire logic [7:0] width,
   input wire logic idle_lvl,
   // Pin
   output logic pin
);
   logic [7:0] left = 8'h00;
   always_ff @(posedge clk_sys)
   begin
      if (start)
         left <= width;
      else if (left != 8'h00)
         left <= left - 8'h01;
   end
   assign pin = (left != 8'h00) ? !idle_lvl : idle_lvl;
endmodule

// ==== testbench/timer_event_pulse_counter_assertions.sv ====
// Port-level assertions and covers for the timer counter
`timescale 1ns/10ps
module timer_event_pulse_counter_assertions
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // Time base, pin and power state
   input wire logic prescaler_clock,
   input wire logic counter_input_pin,
   input wire logic device_idle,
   // Events
   input wire logic irq_req,
   input wire logic wake_up
);
   logic en;
   logic [7:0] ctrl;
   logic [2:0] since;
   wire irq_wr = reg_write && reg_addr == tmr_pkg::ADDR_IRQ;
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         en <= 1'b0;
         ctrl <= tmr_pkg::CTRL_RESET;
      end
      else
      begin
         if (irq_wr)
            en <= reg_wdata[tmr_pkg::IRQ_EN_BIT];
         if (reg_write && reg_addr == tmr_pkg::ADDR_CTRL)
            ctrl <= reg_wdata;
      end
      // Saturates so a long quiet spell cannot wrap into a false recent tick
      since <= prescaler_clock ? 3'h0 : (since == 3'h7 ? since : since + 3'h1);
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data outside its slot");
   a_idle_status: assert property ($past(reg_read && reg_addr == tmr_pkg::ADDR_IRQ)
      |-> reg_rdata[tmr_pkg::IDLE_BIT] == $past(device_idle))
      else $error("idle status bit wrong");
   a_irq_gated: assert property (irq_req |-> $past(en))
      else $error("request without enable");
   a_irq_flag_set: assert property (irq_wr && reg_wdata[1:0] == 2'h3 |-> ##[1:2] irq_req)
      else $error("flag set gave no request");
   a_irq_holds: assert property (irq_req && !irq_wr && !$past(irq_wr) |=> irq_req)
      else $error("request dropped by itself");
   a_wake_idle: assert property (wake_up |-> $past(device_idle))
      else $error("wake while awake");
   a_wake_mode: assert property (wake_up |-> ctrl[7:6] != 2'h0 && ctrl[tmr_pkg::RUN_BIT])
      else $error("overflow while stopped or unused");
   a_wake_tick: assert property (wake_up |-> since <= 3'h4)
      else $error("overflow without a time base pulse");
   c_wake: cover property (wake_up);
   c_irq: cover property ($rose(irq_req));
   c_hi_read: cover property (reg_read && reg_addr == tmr_pkg::ADDR_CNT_HI);
endmodule

bind timer_event_pulse_counter timer_event_pulse_counter_assertions
   u_timer_event_pulse_counter_assertions (
   .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .prescaler_clock(prescaler_clock), .counter_input_pin(counter_input_pin),
   .device_idle(device_idle), .irq_req(irq_req), .wake_up(wake_up));

// ==== testbench/timer_event_pulse_counter_tb.sv ====
// Self-checking bench for the timer counter
`timescale 1ns/10ps
module timer_event_pulse_counter_tb;
   typedef struct {logic [1:0] mode; logic esel; logic [2:0] sel; int npsc; int npulse;
      logic lvl; logic [15:0] exp;} row_t;
   row_t rows [8] = '{'{2'h2, 1'b0, 3'h0, 5, 0, 1'b1, 16'h01aa},
      '{2'h2, 1'b0, 3'h1, 4, 0, 1'b1, 16'h01a7}, '{2'h2, 1'b0, 3'h3, 16, 0, 1'b1, 16'h01a7},
      '{2'h2, 1'b0, 3'h7, 256, 0, 1'b1, 16'h01a7}, '{2'h1, 1'b0, 3'h0, 0, 3, 1'b1, 16'h01a8},
      '{2'h1, 1'b1, 3'h0, 0, 3, 1'b1, 16'h01a8}, '{2'h3, 1'b0, 3'h0, 0, 2, 1'b1, 16'h01b9},
      '{2'h3, 1'b1, 3'h0, 0, 2, 1'b0, 16'h01b9}};
   logic clk_sys, rst, reg_write, reg_read, prescaler_clock, pin, device_idle, irq, wake;
   logic go, lvl;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, q;
   logic [15:0] c;
   int mismatches = 0;
   int n_tests = 0;
   int n_wake = 0;
   timer_event_pulse_counter u_timer_event_pulse_counter (.clk_sys(clk_sys), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .prescaler_clock(prescaler_clock),
      .counter_input_pin(pin), .device_idle(device_idle), .irq_req(irq), .wake_up(wake));
   pin_source u_pin_source (.clk_sys(clk_sys), .start(go), .width(8'h14), .idle_lvl(lvl),
      .pin(pin));
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
      if (wake === 1'b1)
         n_wake++;
   task automatic cyc(int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Strobes drop with a quiet cycle after, so back-to-back calls never collide
   task automatic bus(logic w, logic [1:0] a, logic [7:0] d, output logic [7:0] r);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= w;
      reg_read <= !w;
      @(posedge clk_sys);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      #1 r = reg_rdata;
      @(posedge clk_sys);
   endtask
   task automatic wr(logic [1:0] a, logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd_count(output logic [15:0] v);
      logic [7:0] h, l;
      bus(1'b0, tmr_pkg::ADDR_CNT_HI, 8'h00, h);
      bus(1'b0, tmr_pkg::ADDR_CNT_LO, 8'h00, l);
      v = {h, l};
   endtask
   // Pulse widths may be off by one tick, as the pin is seen only on ticks
   task automatic chk(logic [15:0] got, logic [15:0] exp, logic tol);
      n_tests++;
      if (!(got === exp || (tol && ^got !== 1'bx && got - exp + 16'h1 <= 16'h2)))
      begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #2000000;
      mismatches++;
      complete_run();
   end
   initial
   begin
      {rst, reg_write, reg_read, prescaler_clock, device_idle, go, lvl} = 7'h41;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      foreach (rows[i])
      begin
         rst <= 1'b1;
         lvl <= rows[i].lvl;
         cyc(2);
         rst <= 1'b0;
         wr(tmr_pkg::ADDR_CNT_LO, 8'ha5);
         wr(tmr_pkg::ADDR_CNT_HI, 8'h01);
         wr(tmr_pkg::ADDR_CTRL, {rows[i].mode, 2'h1, rows[i].esel, rows[i].sel});
         prescaler_clock <= 1'b1;
         cyc(rows[i].npsc);
         repeat (rows[i].npulse)
         begin
            go <= 1'b1;
            cyc(1);
            go <= 1'b0;
            cyc(40);
         end
         prescaler_clock <= 1'b0;
         cyc(3);
         bus(1'b0, tmr_pkg::ADDR_CTRL, 8'h00, q);
         chk(q[tmr_pkg::RUN_BIT], rows[i].mode != tmr_pkg::MODE_PULSE, 1'b0);
         rd_count(c);
         chk(c, rows[i].exp, rows[i].mode == 2'h3);
         $display("row %0d done", i);
      end
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      device_idle <= 1'b1;
      wr(tmr_pkg::ADDR_IRQ, 8'h02);
      wr(tmr_pkg::ADDR_CNT_LO, 8'hfe);
      wr(tmr_pkg::ADDR_CNT_HI, 8'hff);
      wr(tmr_pkg::ADDR_CTRL, 8'h90);
      wr(tmr_pkg::ADDR_CNT_LO, 8'h34);
      wr(tmr_pkg::ADDR_CNT_HI, 8'h12);
      prescaler_clock <= 1'b1;
      cyc(3);
      prescaler_clock <= 1'b0;
      cyc(3);
      rd_count(c);
      chk(c, 16'h1235, 1'b0);
      chk(n_wake, 16'h1, 1'b0);
      chk(irq, 16'h1, 1'b0);
      bus(1'b0, tmr_pkg::ADDR_IRQ, 8'h00, q);
      chk(q, 16'h07, 1'b0);
      wr(tmr_pkg::ADDR_IRQ, 8'h02);
      cyc(2);
      chk(irq, 16'h0, 1'b0);
      // Software sets the flag itself, as it would before a halt
      wr(tmr_pkg::ADDR_IRQ, 8'h03);
      cyc(2);
      chk(irq, 16'h1, 1'b0);
      $display("overflow test done");
      complete_run();
   end
endmodule
